// ==== hdl/sfe_front_end.sv ====
// serial front end of a small spi eeprom: framing, decode, pause, guard
`timescale 1ns/10ps

module sfe_front_end (
	input  wire logic             clock_i,     // system clock, 40 MHz
	input  wire logic             rstn_i,      // synchronous reset, low
	input  wire logic             cs_n_i,      // device select pin
	input  wire logic             sck_i,       // serial clock pin
	input  wire logic             si_i,        // serial data in pin
	input  wire logic             hold_n_i,    // pause pin
	input  wire logic             wp_n_i,      // write guard pin
	input  wire logic             prog_busy_i, // core: programming running
	input  wire logic             wel_i,       // core: write latch set
	input  wire logic [7:0]       rd_byte_i,   // core: byte to send
	output logic                  so_o,        // serial data out
	output logic                  so_oe_o,     // serial out enable
	output sfe_pkg::sfe_evt_t     evt_o        // events toward the core
);

	sfe_pkg::sfe_regs_t r_reg;   // registered state
	sfe_pkg::sfe_regs_t r_next;  // next state

	// msb-first byte completion from the shifter and the new bit
	function automatic logic [7:0] full_byte(
		input logic [7:0] sr,
		input logic       bit_in
	);
		full_byte = {sr[6:0], bit_in};
	endfunction : full_byte

	// next address inside the current 8-byte page
	function automatic logic [sfe_pkg::ADDR_W-1:0] page_inc(
		input logic [sfe_pkg::ADDR_W-1:0] a
	);
		logic [sfe_pkg::PAGE_BITS-1:0] lo;
		lo = a[sfe_pkg::PAGE_BITS-1:0] +
			{{(sfe_pkg::PAGE_BITS-1){1'b0}}, 1'b1};
		page_inc = {a[sfe_pkg::ADDR_W-1:sfe_pkg::PAGE_BITS], lo};
	endfunction : page_inc

	// all framing logic in one place
	always_comb
	begin
		logic       rise;   // rising serial clock edge
		logic       fall;   // falling serial clock edge
		logic [7:0] b;      // byte completed at this rising edge
		rise = 1'b0;
		fall = 1'b0;
		b    = 8'h00;
		r_next = r_reg;

		// two-stage synchroniser, only stage two is looked at
		r_next.s1 = '{cs_n: cs_n_i, sck: sck_i, si: si_i,
			hold_n: hold_n_i, wp_n: wp_n_i};
		r_next.s2    = r_reg.s1;
		r_next.sck_d = r_reg.s2.sck;
		r_next.cs_d  = r_reg.s2.cs_n;

		// event strobes last one cycle
		r_next.evt.rd_req  = 1'b0;
		r_next.evt.wr_byte = 1'b0;
		r_next.evt.commit  = 1'b0;

		// page step one clock after the write strobe, so the core
		// sees the strobe together with the address it belongs to
		if (r_reg.evt.wr_byte && r_reg.evt.op == sfe_pkg::OP_ARRAY_WR)
		begin
			r_next.evt.addr = page_inc(r_reg.evt.addr);
		end

		// both modes capture on rising edges, so idle level is irrelevant
		rise = r_reg.s2.sck & ~r_reg.sck_d;
		fall = ~r_reg.s2.sck & r_reg.sck_d;

		if (r_reg.s2.cs_n)
		begin
			// select rising: execute a cleanly ended command
			if (!r_reg.cs_d && r_reg.pend && r_reg.bitc == 3'h0 &&
				(r_reg.wr_ok ||
				r_reg.evt.op == sfe_pkg::OP_CLEAR_LATCH))
			begin
				r_next.evt.commit = 1'b1;
			end
			// deselected: nothing shifts, output released
			r_next.st    = sfe_pkg::ST_IDLE;
			r_next.so_oe = 1'b0;
			r_next.held  = 1'b0;
			r_next.pend  = 1'b0;
		end
		else if (r_reg.cs_d)
		begin
			// select falling: fresh frame, framing restarts
			r_next.st    = sfe_pkg::ST_OPC;
			r_next.bitc  = 3'h0;
			r_next.held  = 1'b0;
			r_next.pend  = 1'b0;
			r_next.wr_ok = r_reg.s2.wp_n;
			r_next.so_oe = 1'b0;
		end
		else
		begin
			// pause enters and leaves at any clock level, never entered in ST_DEAD
			if (!r_reg.s2.hold_n && r_reg.st != sfe_pkg::ST_DEAD)
			begin
				r_next.held = 1'b1;
			end
			else if (r_reg.s2.hold_n)
			begin
				r_next.held = 1'b0;
			end

			// guard fall while selected kills a pending write;
			// a cycle already started in the core is not ours to stop
			if (!r_reg.s2.wp_n)
			begin
				r_next.wr_ok = 1'b0;
			end

			// edges during a pause are dropped, state frozen
			if (!r_reg.held && rise &&
				(r_reg.st == sfe_pkg::ST_OPC ||
				r_reg.st == sfe_pkg::ST_ADDR ||
				r_reg.st == sfe_pkg::ST_DATA))
			begin
				b = full_byte(r_reg.in_sr, r_reg.s2.si);
				r_next.in_sr = b;
				r_next.bitc  = r_reg.bitc + 3'h1;
				if (r_reg.bitc == 3'h7)
				begin
					unique case (r_reg.st)
						sfe_pkg::ST_OPC:
						begin
							r_next.evt.op = b[2:0];
							if (b[7:4] != sfe_pkg::OPC_HI_ZERO)
							begin
								// not an instruction at all
								r_next.st = sfe_pkg::ST_DEAD;
							end
							else if (prog_busy_i &&
								b[2:0] != sfe_pkg::OP_STATUS_RD)
							begin
								r_next.st = sfe_pkg::ST_DEAD;
							end
							else
							begin
								unique case (b[2:0])
									sfe_pkg::OP_SET_LATCH:
									begin
										r_next.pend = 1'b1;
										r_next.st   = sfe_pkg::ST_DEAD;
									end
									sfe_pkg::OP_CLEAR_LATCH:
									begin
										r_next.pend = 1'b1;
										r_next.st   = sfe_pkg::ST_DEAD;
									end
									sfe_pkg::OP_STATUS_RD:
									begin
										r_next.st         = sfe_pkg::ST_OUT;
										r_next.evt.rd_req = 1'b1;
									end
									sfe_pkg::OP_STATUS_WR:
									begin
										r_next.st    = sfe_pkg::ST_DATA;
										r_next.wr_ok = r_next.wr_ok
											& wel_i;
									end
									sfe_pkg::OP_ARRAY_RD:
									begin
										r_next.st = sfe_pkg::ST_ADDR;
										r_next.evt.addr[sfe_pkg::ADDR_W-1] =
											b[sfe_pkg::OPC_AMSB_POS];
									end
									sfe_pkg::OP_ARRAY_WR:
									begin
										r_next.st    = sfe_pkg::ST_ADDR;
										r_next.wr_ok = r_next.wr_ok
											& wel_i;
										r_next.evt.addr[sfe_pkg::ADDR_W-1] =
											b[sfe_pkg::OPC_AMSB_POS];
									end
									default:
									begin
										// 000 and 111 match nothing
										r_next.st = sfe_pkg::ST_DEAD;
									end
								endcase
							end
						end
						sfe_pkg::ST_ADDR:
						begin
							r_next.evt.addr[7:0] = b;
							if (r_reg.evt.op == sfe_pkg::OP_ARRAY_RD)
							begin
								// later si bits are don't-care
								r_next.st         = sfe_pkg::ST_OUT;
								r_next.evt.rd_req = 1'b1;
							end
							else
							begin
								r_next.st = sfe_pkg::ST_DATA;
							end
						end
						sfe_pkg::ST_DATA:
						begin
							r_next.evt.data    = b;
							r_next.pend        = 1'b1;
							r_next.evt.wr_byte = r_next.wr_ok;
							if (r_reg.evt.op != sfe_pkg::OP_ARRAY_WR)
							begin
								// status write takes one byte only
								r_next.st = sfe_pkg::ST_DEAD;
							end
						end
						default:
						begin
							r_next.st = r_reg.st;
						end
					endcase
				end
			end

			// outgoing bits change after falling edges only
			if (!r_reg.held && fall && r_reg.st == sfe_pkg::ST_OUT)
			begin
				r_next.bitc = r_reg.bitc + 3'h1;
				if (r_reg.bitc == 3'h0)
				begin
					// core had at least half a serial clock period to present the byte
					r_next.so     = rd_byte_i[7];
					r_next.out_sr = {rd_byte_i[6:0], 1'b0};
				end
				else
				begin
					r_next.so     = r_reg.out_sr[7];
					r_next.out_sr = {r_reg.out_sr[6:0], 1'b0};
				end
				if (r_reg.bitc == 3'h7)
				begin
					// last bit gone: fetch the next byte, full wrap
					r_next.evt.rd_req = 1'b1;
					if (r_reg.evt.op == sfe_pkg::OP_ARRAY_RD)
					begin
						r_next.evt.addr = r_reg.evt.addr +
							{{(sfe_pkg::ADDR_W-1){1'b0}}, 1'b1};
					end
				end
			end

			// so driven only while reading and not paused;
			// si is ignored whenever so is on, by the state gate above
			r_next.so_oe = (r_next.st == sfe_pkg::ST_OUT) &
				~r_next.held;
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			r_reg <= sfe_pkg::REGS_RST;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign so_o    = r_reg.so;
	assign so_oe_o = r_reg.so_oe;
	assign evt_o   = r_reg.evt;

endmodule : sfe_front_end

// ==== hdl/sfe_pkg.sv ====
// package: constants and types of the serial eeprom front end
package sfe_pkg;

	// op-code layout: upper nibble zero, bit 3 address msb or don't-care
	localparam int            OPC_BITS      = 8;
	localparam int            OPC_AMSB_POS  = 3;
	localparam logic [3:0]    OPC_HI_ZERO   = 4'h0;
	localparam int            ADDR_W        = 9;
	localparam int            PAGE_BITS     = 3;

	// low three op-code bits of the six instructions
	localparam logic [2:0]    OP_SET_LATCH   = 3'h6;
	localparam logic [2:0]    OP_CLEAR_LATCH = 3'h4;
	localparam logic [2:0]    OP_STATUS_RD   = 3'h5;
	localparam logic [2:0]    OP_STATUS_WR   = 3'h1;
	localparam logic [2:0]    OP_ARRAY_RD    = 3'h3;
	localparam logic [2:0]    OP_ARRAY_WR    = 3'h2;

	// sampled pins, travel together through the synchroniser
	typedef struct packed {
		logic cs_n;    // device select, low active
		logic sck;     // serial clock from the master
		logic si;      // serial data in
		logic hold_n;  // pause input, low active
		logic wp_n;    // write guard, low blocks writes
	} sfe_pins_t;

	// idle pin levels: deselected, no pause, writes allowed
	localparam sfe_pins_t     PINS_RST      = 5'h13;

	// framing states
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,  // deselected
		ST_OPC   = 6'h02,  // shifting the op-code byte
		ST_ADDR  = 6'h04,  // shifting the low address byte
		ST_DATA  = 6'h08,  // shifting write data bytes
		ST_OUT   = 6'h10,  // shifting read data out
		ST_DEAD  = 6'h20   // input ignored until select falls again
	} sfe_state_t;

	// events toward the memory core
	typedef struct packed {
		logic              rd_req;   // pulse: present byte at addr
		logic              wr_byte;  // pulse: data byte for addr
		logic              commit;   // pulse: execute op at select rise
		logic [2:0]        op;       // low op-code bits of current frame
		logic [ADDR_W-1:0] addr;     // current array address
		logic [7:0]        data;     // last received data byte
	} sfe_evt_t;

	// whole state of the front end
	typedef struct packed {
		sfe_pins_t         s1;       // first synchroniser stage
		sfe_pins_t         s2;       // second synchroniser stage
		logic              sck_d;    // delayed clock for edge finding
		logic              cs_d;     // delayed select for edge finding
		sfe_state_t        st;
		logic [2:0]        bitc;     // bit position within the byte
		logic [7:0]        in_sr;    // 8-bit instruction/data shifter
		logic [7:0]        out_sr;   // outgoing byte shifter
		logic              held;     // pause in force
		logic              wr_ok;    // write still allowed this frame
		logic              pend;     // frame holds a command to commit
		logic              so;       // serial out level
		logic              so_oe;    // serial out enable
		sfe_evt_t          evt;
	} sfe_regs_t;

	localparam sfe_regs_t     REGS_RST = '{
		s1:     PINS_RST,
		s2:     PINS_RST,
		sck_d:  1'b0,
		cs_d:   1'b1,
		st:     ST_IDLE,
		bitc:   3'h0,
		in_sr:  8'h00,
		out_sr: 8'h00,
		held:   1'b0,
		wr_ok:  1'b0,
		pend:   1'b0,
		so:     1'b0,
		so_oe:  1'b0,
		evt:    '0
	};

endpackage : sfe_pkg

// ==== tb/sfe_front_end_properties.sv ====
// checker: pin-level timing relations of the front end
`timescale 1ns/10ps

module sfe_front_end_properties (
	input wire logic              clock_i,
	input wire logic              rstn_i,
	input wire logic              cs_n_i,
	input wire logic              sck_i,
	input wire logic              si_i,
	input wire logic              hold_n_i,
	input wire logic              wp_n_i,
	input wire logic              prog_busy_i,
	input wire logic              wel_i,
	input wire logic [7:0]        rd_byte_i,
	input wire logic              so_o,
	input wire logic              so_oe_o,
	input wire sfe_pkg::sfe_evt_t evt_o
);
	// one domain: pins reach the state in three clocks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	chk_desel_quiet: assert property (cs_n_i [*6] |-> !so_oe_o)
		else $error("serial out driven while deselected");
	chk_pause_quiet: assert property (!hold_n_i [*6] |-> !so_oe_o)
		else $error("serial out driven during pause");
	chk_out_fall: assert property (so_oe_o && $past(so_oe_o)
		&& $changed(so_o) |-> !sck_i && !$past(sck_i, 2))
		else $error("serial out moved outside clock low");
	chk_commit_desel: assert property (evt_o.commit |-> cs_n_i)
		else $error("commit while still selected");
	chk_wr_guard: assert property (evt_o.wr_byte |-> wp_n_i && wel_i)
		else $error("write byte despite guard or latch");
	chk_commit_busy: assert property (evt_o.commit |-> !prog_busy_i)
		else $error("commit accepted while programming");
	chk_page_wrap: assert property (evt_o.wr_byte &&
		evt_o.op == sfe_pkg::OP_ARRAY_WR |-> ##1
		evt_o.addr[2:0] == $past(evt_o.addr[2:0], 1) + 3'h1)
		else $error("page address did not step");
	chk_read_on: assert property (evt_o.rd_req |-> ##[0:1] so_oe_o)
		else $error("read request without output enabled");
endmodule : sfe_front_end_properties

bind sfe_front_end sfe_front_end_properties u_chk (
	.clock_i(clock_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
	.si_i(si_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i),
	.prog_busy_i(prog_busy_i), .wel_i(wel_i), .rd_byte_i(rd_byte_i),
	.so_o(so_o), .so_oe_o(so_oe_o), .evt_o(evt_o));

// ==== tb/sfe_spi_master.sv ====
// partner: spi master in mode 0, paced by the system clock
`timescale 1ns/10ps

module sfe_spi_master (
	input  wire logic clock_i,  // paces the link
	input  wire logic so_i,     // resolved serial out wire
	output logic      cs_n_o,   // select, low active
	output logic      sck_o,    // link clock, still between frames
	output logic      si_o,     // data toward the device
	output logic      hold_n_o  // pause, low active
);
	localparam int HALF = 4;  // clocks per half period, 200 ns period

	// idle levels at time zero
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		hold_n_o = 1'b1;
	end

	// select edge, margin both sides covers commit latency
	task automatic sel(input logic lvl);
		repeat (HALF) @(posedge clock_i);
		cs_n_o <= lvl;  // each frame opens on a fall
		si_o <= ~si_o;  // released data never keeps its last value
		repeat (3 * HALF) @(posedge clock_i);
	endtask : sel

	// one byte, pause before bit hp (-1 for none)
	task automatic xfer(input logic [7:0] tx, input int hp,
		output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			if (i == hp)
			begin
				// let the clock fall settle before pausing
				repeat (HALF / 2) @(posedge clock_i);
				hold_n_o <= 1'b0;  // only while clock low
				si_o <= ~si_o;
				repeat (4)
				begin
					repeat (HALF) @(posedge clock_i);
					sck_o <= ~sck_o;  // clock runs on in pause
				end
				repeat (HALF) @(posedge clock_i);
				hold_n_o <= 1'b1;  // released with clock low
			end
			si_o <= tx[i];  // msb first
			repeat (HALF) @(posedge clock_i);
			sck_o <= 1'b1;
			rx[i] = so_i;  // capture on rising edge
			repeat (HALF) @(posedge clock_i);
			sck_o <= 1'b0;
		end
	endtask : xfer
endmodule : sfe_spi_master

// ==== tb/spi_eeprom_serial_front_end_test.sv ====
// bench: random and hand-made frames through the front end
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
	bad_count++; $display("FAIL %0t got %h exp %h", $time, got, exp); \
	end end

module spi_eeprom_serial_front_end_test;
	logic              clock_i = 1'b0;     // 40 MHz
	logic              rstn_i;             // reset, held at start
	logic              wp_n_i;             // write guard
	logic              prog_busy_i;        // core programming
	logic              wel_i;              // core write latch
	logic [7:0]        rd_byte_i;          // core data to send
	logic              cs_n_i, sck_i, si_i, hold_n_i;
	logic              so_o, so_oe_o;
	wire               so_w;               // resolved serial out pin
	sfe_pkg::sfe_evt_t evt_o;
	int                bad_count = 0, cmp_count = 0, seed = 35;
	int                n_com = 0, n_wr = 0, n_oe = 0;  // event tallies
	logic [2:0]        last_op;            // op of last commit
	logic [7:0]        rx;

	always #12.5 clock_i = ~clock_i;
	assign so_w = so_oe_o ? so_o : 1'bz;

	// tally one-cycle events, pulses are too short to poll
	always @(posedge clock_i)
	begin
		n_com <= n_com + int'(evt_o.commit === 1'b1);
		n_wr <= n_wr + int'(evt_o.wr_byte === 1'b1);
		n_oe <= n_oe + int'(so_oe_o === 1'b1);
		if (evt_o.commit === 1'b1)
			last_op <= evt_o.op;
	end

	sfe_front_end DUT (.clock_i(clock_i), .rstn_i(rstn_i),
		.cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .hold_n_i(hold_n_i),
		.wp_n_i(wp_n_i), .prog_busy_i(prog_busy_i), .wel_i(wel_i),
		.rd_byte_i(rd_byte_i), .so_o(so_o), .so_oe_o(so_oe_o),
		.evt_o(evt_o));
	sfe_spi_master u_mst (.clock_i(clock_i), .so_i(so_w), .cs_n_o(cs_n_i),
		.sck_o(sck_i), .si_o(si_i), .hold_n_o(hold_n_i));

	// whether a finished frame must reach the core
	function automatic logic exp_commit(input logic [7:0] op);
		if (op[7:4] != 4'h0 || prog_busy_i)
			return 1'b0;
		case (op[2:0])
			sfe_pkg::OP_SET_LATCH:   return wp_n_i;
			sfe_pkg::OP_CLEAR_LATCH: return 1'b1;
			sfe_pkg::OP_STATUS_WR,
			sfe_pkg::OP_ARRAY_WR:    return wel_i & wp_n_i;
			default:                 return 1'b0;
		endcase
	endfunction : exp_commit

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	initial
	begin
		int c0, w0, o0;
		logic [31:0] r;
		logic [7:0] op;
		logic bad;
		logic wr_op;
		rstn_i <= 1'b0;
		wp_n_i <= 1'b1;
		prog_busy_i <= 1'b0;
		wel_i <= 1'b0;
		rd_byte_i <= 8'h00;
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(posedge clock_i);
		`CHK(so_oe_o, 1'b0)
		// every code once, then random frames
		for (int i = 0; i < 48; i++)
		begin
			r = $random(seed);
			op = (i < 8) ? {4'h0, r[3], 3'(i)} : r[7:0];
			if (r[8])
				op[7:4] = 4'h0;
			wel_i <= r[9] | (i < 8);
			wp_n_i <= r[10] | (i < 8);
			prog_busy_i <= r[11] & r[12] & (i >= 8);
			rd_byte_i <= r[20:13];
			@(posedge clock_i);
			bad = op[7:4] != 4'h0 || op[2:0] == 3'h0 || op[2:0] == 3'h7
				|| (prog_busy_i && op[2:0] != sfe_pkg::OP_STATUS_RD);
			// both write kinds hand their data byte to the core
			wr_op = op[2:0] == sfe_pkg::OP_STATUS_WR
				|| op[2:0] == sfe_pkg::OP_ARRAY_WR;
			c0 = n_com;
			w0 = n_wr;
			o0 = n_oe;
			u_mst.sel(1'b0);
			u_mst.xfer(op, -1, rx);
			u_mst.xfer(r[28:21], -1, rx);
			u_mst.xfer(r[31:24], -1, rx);
			u_mst.sel(1'b1);
			`CHK(n_com - c0, int'(exp_commit(op)))
			`CHK(n_wr - w0, int'(exp_commit(op) && wr_op))
			if (bad)
				`CHK(n_oe - o0, 0)
			if (!bad && op[2:0] == sfe_pkg::OP_ARRAY_RD)
				`CHK(rx, rd_byte_i)
			if (exp_commit(op))
				`CHK(last_op, op[2:0])
		end
		// read over the top of the array, paused mid byte
		prog_busy_i <= 1'b0;
		rd_byte_i <= 8'hA5;
		u_mst.sel(1'b0);
		u_mst.xfer(8'h0B, -1, rx);
		u_mst.xfer(8'hFF, -1, rx);
		repeat (6) @(posedge clock_i);
		`CHK(evt_o.addr, 9'h1FF)
		u_mst.xfer(8'h00, 3, rx);
		repeat (6) @(posedge clock_i);
		`CHK(rx, 8'hA5)
		`CHK(evt_o.addr, 9'h000)
		u_mst.sel(1'b1);
		// page write with a pause, then one cut by the guard
		for (int k = 0; k < 2; k++)
		begin
			wel_i <= 1'b1;
			wp_n_i <= 1'b1;
			c0 = n_com;
			w0 = n_wr;
			u_mst.sel(1'b0);
			u_mst.xfer(8'h0A, -1, rx);
			u_mst.xfer(8'h37, 5, rx);
			if (k == 1)
				wp_n_i <= 1'b0;
			u_mst.xfer(8'hC5, -1, rx);
			repeat (6) @(posedge clock_i);
			if (k == 0)
				`CHK(evt_o.addr, 9'h130)
			u_mst.sel(1'b1);
			`CHK(n_wr - w0, 1 - k)
			`CHK(n_com - c0, 1 - k)
			if (k == 0)
			begin
				// guard fall after the commit changes nothing
				wp_n_i <= 1'b0;
				repeat (6) @(posedge clock_i);
				`CHK(n_com - c0, 1)
			end
		end
		test_done();
	end
endmodule : spi_eeprom_serial_front_end_test
